/* File: tb_top.sv */
// Self-checking bench for the channel value coherency block
`timescale 1ns/10ps
module tb_top;
  localparam logic [5:0] k_hw = 6'h20, k_lw = 6'h10, k_hr = 6'h08, k_lr = 6'h04, k_sc = 6'h02, k_cp = 6'h01;
  localparam int lim = 70000;
  logic        mclk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [1:0]  src = 2'h0;
  logic [2:0]  pre = 3'h0;
  logic        cen = 1'b0;
  logic [15:0] modv = 16'h0000;
  logic        ftk = 1'b0;
  logic        ext = 1'b0;
  logic [1:0]  mode = 2'h1;
  logic        sc = 1'b0;
  logic        dbg = 1'b0;
  logic        cap = 1'b0;
  logic        hw = 1'b0;
  logic        lw = 1'b0;
  logic [7:0]  wd = 8'h00;
  logic        hr = 1'b0;
  logic        lr = 1'b0;
  wire  [7:0]  rd;
  wire         rv;
  wire  [15:0] val;
  wire  [15:0] ctr;
  wire         tick;
  wire         pend;
  wire         rlat;
  integer      seed = 94;
  integer      error_cnt = 0;
  integer      compares = 0;
  logic [15:0] w;
  logic [15:0] cur = 16'h0000;
  logic [15:0] pc_q = 16'h0000;
  logic        pt_q = 1'b0;
  logic [1:0]  ph = 2'h0;
  wire         mt;
  wire         pin;
  logic [18:0] tbl [4] = '{{2'h2, 1'b0, 16'h0020}, {2'h3, 1'b0, 16'h0011}, {2'h1, 1'b1, 16'h0018},
                           {2'h2, 1'b0, 16'h0000}};

  always #5 mclk_in = ~mclk_in;

  // Counter and tick of the cycle that each edge closes
  always @(posedge mclk_in)
  begin
    pc_q <= ctr;
    pt_q <= tick;
  end

  tvc_channel_value dut
  (
    .mclk_in                      (mclk_in),
    .rst_n_in                     (rst_n_in),
    .clock_source_select_in       (src),
    .prescale_sel_in              (pre),
    .center_aligned_select_in     (cen),
    .counter_modulo_value_in      (modv),
    .fixed_tick_in                (ftk),
    .ext_clk_in                   (ext),
    .chan_mode_in                 (mode),
    .channel_status_control_wr_in (sc),
    .background_debug_active_in   (dbg),
    .capture_in                   (cap),
    .channel_value_high_wr_in     (hw),
    .channel_value_low_wr_in      (lw),
    .wr_data_in                   (wd),
    .channel_value_high_rd_in     (hr),
    .channel_value_low_rd_in      (lr),
    .rd_data_out                  (rd),
    .rd_valid_out                 (rv),
    .channel_value_out            (val),
    .counter_out                  (ctr),
    .counter_tick_out             (tick),
    .pair_pending_out             (pend),
    .read_latched_out             (rlat),
    .match_out                    (mt),
    .channel_pin_out              (pin)
  );

  task automatic give_verdict();
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  function automatic logic [15:0] top_step(input logic [15:0] m);
    return (m == 16'h0000) ? 16'hfffe : m - 16'h0001;
  endfunction

  // One cycle of strobes, driven at the falling edge
  task automatic st(input logic [5:0] s, input logic [7:0] d);
    @(negedge mclk_in);
    {hw, lw, hr, lr, sc, cap} = s;
    wd = d;
    ftk = ($random(seed) & 1) != 0;
    // Slow pin clock so each level reaches two synchroniser stages
    ph = ph + 2'h1;
    ext = ph[1];
  endtask

  task automatic pr(input logic [15:0] x, input logic lo1);
    st(lo1 ? k_lw : k_hw, lo1 ? x[7:0] : x[15:8]);
    st(lo1 ? k_hw : k_lw, lo1 ? x[15:8] : x[7:0]);
    chk("value before pair", val, cur);
    st(6'h00, 8'h00);
  endtask

  task automatic rdb(input logic [5:0] s, input logic [7:0] e);
    st(s, 8'h00);
    st(6'h00, 8'h00);
    chk("read data", {7'h00, rv, rd}, {8'h01, e});
  endtask

  // Idle until the value lands, noting the cycle that moved it
  task automatic wt(input logic [15:0] exp, input logic use_ctr, input logic [15:0] ce);
    int i;
    i = 0;
    while (val !== exp && i < lim)
    begin
      st(6'h00, 8'h00);
      i++;
    end
    if (val !== exp)
    begin
      error_cnt++;
      give_verdict();
    end
    else
      chk("update point", use_ctr ? pc_q : {15'h0000, pt_q}, use_ctr ? ce : 16'h0001);
  endtask

  initial
  begin
    repeat (20) @(negedge mclk_in);
    rst_n_in = 1'b1;
    for (int k = 0; k < 8; k++)
    begin
      w = 16'($random(seed));
      pr(w, k[0]);
      chk("value off", val, w);
      cur = w;
    end
    $display("test pairs finished");
    rdb(k_hr, cur[15:8]);
    pr(16'h5aa5, 1'b0);
    rdb(k_lr, cur[7:0]);
    cur = 16'h5aa5;
    rdb(k_lr, cur[7:0]);
    st(k_sc, 8'h00);
    st(6'h00, 8'h00);
    chk("read latch", {15'h0000, rlat}, 16'h0000);
    st(k_hw, 8'h12);
    st(k_sc, 8'h00);
    st(k_lw, 8'h34);
    st(6'h00, 8'h00);
    chk("pending", {15'h0000, pend}, 16'h0001);
    st(k_hw, 8'h56);
    st(6'h00, 8'h00);
    chk("value", val, 16'h5634);
    $display("test latches finished");
    mode = 2'h0;
    st(k_cp, 8'h00);
    st(6'h00, 8'h00);
    cur = 16'h0000;
    chk("capture", val, cur);
    chk("capture pin", {14'h0000, mt, pin}, 16'h0000);
    pr(16'h1234, 1'b1);
    chk("capture write", val, cur);
    mode = 2'h1;
    st(k_hw, 8'hc3);
    rdb(k_hr, cur[15:8]);
    dbg = 1'b1;
    st(k_lw, 8'h3c);
    st(k_hw, 8'h77);
    st(6'h00, 8'h00);
    chk("debug write", val, 16'h773c);
    chk("pending", {15'h0000, pend}, 16'h0001);
    rdb(k_lr, 8'h3c);
    rdb(k_hr, 8'h77);
    chk("read latch", {15'h0000, rlat}, 16'h0001);
    dbg = 1'b0;
    rdb(k_lr, cur[7:0]);
    st(k_lw, 8'h99);
    st(6'h00, 8'h00);
    cur = 16'hc399;
    chk("value", val, cur);
    $display("test debug finished");
    pre = 3'h1;
    for (int s = 1; s < 4; s++)
    begin
      src = 2'(s);
      w = 16'($random(seed));
      pr(w, s[0]);
      wt(w, 1'b0, 16'h0000);
      cur = w;
    end
    src = 2'h1;
    pre = 3'h0;
    for (int k = 0; k < 4; k++)
    begin
      {mode, cen, modv} = tbl[k];
      w = 16'($random(seed));
      pr(w, k[0]);
      wt(w, 1'b1, top_step(modv));
      cur = w;
    end
    $display("test counted finished");
    give_verdict();
  end
endmodule // tb_top

bind tvc_channel_value tvc_chk u_chk
(
  .mclk_in, .rst_n_in, .clock_source_select_in, .counter_modulo_value_in, .chan_mode_in,
  .channel_status_control_wr_in, .background_debug_active_in, .capture_in, .channel_value_high_wr_in,
  .channel_value_low_wr_in, .wr_data_in, .channel_value_high_rd_in, .channel_value_low_rd_in, .rd_data_out,
  .channel_value_out, .counter_out, .counter_tick_out, .pair_pending_out, .read_latched_out
);

/* File: tvc_channel_value.v */
// Timer channel with coherent byte-wise access to its 16-bit value
`timescale 1ns/10ps
`include "tvc_consts.vh"
// What this block does
// - A channel status and control write releases the read latch, in or out of background debug.
// - In input capture mode every value byte write is dropped and the captured value kept.
// - In background debug the read latch keeps its entry state; only a status and control write resets it.
// - A value byte read in background debug returns the live channel value, not the read buffer.
// - In compare or pulse modes each byte write goes to a buffer and both move together once both are written.
// - With the clock source off the channel value updates as soon as the second byte is written.
// - With a clock source in compare mode the pair is applied at the next counter change.
// - With a clock source in pulse modes the pair is applied when the counter steps from modulo minus one to modulo.
// - With a free-running counter in pulse modes the pair is applied on the step from 0xfffe to 0xffff.
// - A status and control write discards any half-written pair, in or out of background debug.
// - The two bytes may be written in either order and still form one update.
// - In background debug byte writes leave the write latches as they are; a status and control write or the update of a complete pending pair still clears them.
// - In background debug, outside input capture mode, a byte write goes straight into the channel value, bypassing the buffer.
// - Debug writes leave a partial pair intact, which later completes from the buffered bytes.
// - A central 16-bit counter has a selectable source, a prescaler and a modulo bound.
// - With center-aligned pulses selected the counter runs up and down, otherwise only up.

module tvc_channel_value
(
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // Timer configuration
  input  wire [1:0]  clock_source_select_in,
  input  wire [2:0]  prescale_sel_in,
  input  wire        center_aligned_select_in,
  input  wire [15:0] counter_modulo_value_in,
  input  wire        fixed_tick_in,
  input  wire        ext_clk_in,
  // Channel configuration
  input  wire [1:0]  chan_mode_in,
  input  wire        channel_status_control_wr_in,
  input  wire        background_debug_active_in,
  input  wire        capture_in,
  // Channel value byte access
  input  wire        channel_value_high_wr_in,
  input  wire        channel_value_low_wr_in,
  input  wire [7:0]  wr_data_in,
  input  wire        channel_value_high_rd_in,
  input  wire        channel_value_low_rd_in,
  output reg  [7:0]  rd_data_out,
  output reg         rd_valid_out,
  // Channel state
  output reg  [15:0] channel_value_out,
  output wire [15:0] counter_out,
  output wire        counter_tick_out,
  output reg         pair_pending_out,
  output reg         read_latched_out,
  output reg         match_out,
  output reg         channel_pin_out
);

  wire        count_up;
  wire [15:0] top;
  wire        dbg;
  wire        pair_done;
  wire [1:0]  lane_wr;
  wire [1:0]  lane_take;
  wire [1:0]  lane_have;
  wire [15:0] lane_data;
  wire        lat_hi_eff;
  wire        lat_lo_eff;
  reg         mode_capture;
  reg         mode_pulse;
  reg         mode_compare;
  reg         apply_ok;
  reg  [1:0]  held;
  reg  [15:0] buf_pair;
  reg         rd_lat_hi;
  reg         rd_lat_lo;
  reg  [7:0]  rd_buf;
  reg  [1:0]  next_held;
  reg  [15:0] next_value;
  reg         next_rd_lat_hi;
  reg         next_rd_lat_lo;
  reg  [7:0]  next_rd_buf;
  reg  [7:0]  next_rd_data;
  genvar      lane;

  tvc_counter u_counter
  (
    .mclk_in                  (mclk_in),
    .rst_n_in                 (rst_n_in),
    .clock_source_select_in   (clock_source_select_in),
    .prescale_sel_in          (prescale_sel_in),
    .center_aligned_select_in (center_aligned_select_in),
    .counter_modulo_value_in  (counter_modulo_value_in),
    .fixed_tick_in            (fixed_tick_in),
    .ext_clk_in               (ext_clk_in),
    .count_out                (counter_out),
    .count_up_out             (count_up),
    .tick_out                 (counter_tick_out),
    .top_out                  (top)
  );

  assign dbg        = background_debug_active_in;
  assign pair_done  = &lane_have;
  assign lane_wr    = {channel_value_high_wr_in, channel_value_low_wr_in};

  // Latch release takes effect before a read in the same cycle, so that read sets it anew
  assign lat_hi_eff = rd_lat_hi & ~channel_status_control_wr_in;
  assign lat_lo_eff = rd_lat_lo & ~channel_status_control_wr_in;

  // Channel mode; center-aligned selection overrides every channel mode
  always @*
  begin
    mode_capture = 1'b0;
    mode_compare = 1'b0;
    mode_pulse   = 1'b0;
    if (center_aligned_select_in)
      mode_pulse = 1'b1;
    else
    begin
      case (chan_mode_in)
        `TVC_MODE_CAPTURE:   mode_capture = 1'b1;
        `TVC_MODE_COMPARE:   mode_compare = 1'b1;
        `TVC_MODE_EDGE_PWM:  mode_pulse   = 1'b1;
        `TVC_MODE_EDGE_PWM2: mode_pulse   = 1'b1;
        default:             mode_pulse   = 1'b1;
      endcase
    end
  end

  // Per byte lane; a held half cleared by a status write is set again by a byte of the same cycle
  generate
    for (lane = 0; lane < `TVC_LANES; lane = lane + 1)
    begin : g_lane
      assign lane_take[lane] = lane_wr[lane] & ~dbg & ~mode_capture;
      assign lane_have[lane] = (held[lane] & ~channel_status_control_wr_in) | lane_take[lane];
      assign lane_data[lane*`TVC_BYTE_W +: `TVC_BYTE_W] = lane_take[lane] ? wr_data_in
                                                      : buf_pair[lane*`TVC_BYTE_W +: `TVC_BYTE_W];
    end
  endgenerate

  // When a completed pair may move into the channel value
  always @*
  begin
    if (clock_source_select_in == `TVC_CLK_OFF)
      apply_ok = 1'b1;
    else if (mode_compare)
      apply_ok = counter_tick_out;
    else if (mode_pulse)
      apply_ok = counter_tick_out & count_up & (counter_out == top - `TVC_ONE);
    else
      apply_ok = 1'b0;
  end

  // Write side: a pair completes in the cycle its last byte arrives, so clock-off needs no extra wait
  always @*
  begin
    next_held  = lane_have;
    next_value = channel_value_out;
    if (pair_done && apply_ok && !mode_capture)
    begin
      next_value = lane_data;
      next_held  = `TVC_HELD_RST;
    end
    if (mode_capture)
    begin
      if (capture_in)
        next_value = counter_out;
    end
    else if (dbg)
    begin
      // Debug bytes bypass the buffer and leave the held halves alone
      if (channel_value_high_wr_in)
        next_value[`TVC_HI_MSB:`TVC_HI_LSB] = wr_data_in;
      if (channel_value_low_wr_in)
        next_value[`TVC_LO_MSB:`TVC_LO_LSB] = wr_data_in;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      held              <= `TVC_HELD_RST;
      buf_pair          <= `TVC_VALUE_RST;
      channel_value_out <= `TVC_VALUE_RST;
      pair_pending_out  <= 1'b0;
    end
    else
    begin
      held              <= next_held;
      buf_pair          <= lane_data;
      channel_value_out <= next_value;
      pair_pending_out  <= |next_held;
    end
  end

  // Read side: one half read latches the other
  always @*
  begin
    next_rd_lat_hi = lat_hi_eff;
    next_rd_lat_lo = lat_lo_eff;
    next_rd_buf    = rd_buf;
    next_rd_data   = rd_data_out;
    if (channel_value_high_rd_in)
    begin
      if (dbg)
        next_rd_data = channel_value_out[`TVC_HI_MSB:`TVC_HI_LSB];
      else if (lat_hi_eff)
      begin
        next_rd_data   = rd_buf;
        next_rd_lat_hi = 1'b0;
      end
      else
      begin
        next_rd_data   = channel_value_out[`TVC_HI_MSB:`TVC_HI_LSB];
        next_rd_buf    = channel_value_out[`TVC_LO_MSB:`TVC_LO_LSB];
        next_rd_lat_lo = 1'b1;
        next_rd_lat_hi = 1'b0;
      end
    end
    else if (channel_value_low_rd_in)
    begin
      if (dbg)
        next_rd_data = channel_value_out[`TVC_LO_MSB:`TVC_LO_LSB];
      else if (lat_lo_eff)
      begin
        next_rd_data   = rd_buf;
        next_rd_lat_lo = 1'b0;
      end
      else
      begin
        next_rd_data   = channel_value_out[`TVC_LO_MSB:`TVC_LO_LSB];
        next_rd_buf    = channel_value_out[`TVC_HI_MSB:`TVC_HI_LSB];
        next_rd_lat_hi = 1'b1;
        next_rd_lat_lo = 1'b0;
      end
    end
  end

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      rd_lat_hi        <= 1'b0;
      rd_lat_lo        <= 1'b0;
      rd_buf           <= `TVC_BYTE_RST;
      rd_data_out      <= `TVC_BYTE_RST;
      rd_valid_out     <= 1'b0;
      read_latched_out <= 1'b0;
    end
    else
    begin
      rd_lat_hi        <= next_rd_lat_hi;
      rd_lat_lo        <= next_rd_lat_lo;
      rd_buf           <= next_rd_buf;
      rd_data_out      <= next_rd_data;
      rd_valid_out     <= channel_value_high_rd_in | channel_value_low_rd_in;
      read_latched_out <= next_rd_lat_hi | next_rd_lat_lo;
    end
  end

  // Match pulse and channel pin from the applied value
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      match_out       <= 1'b0;
      channel_pin_out <= 1'b0;
    end
    else
    begin
      match_out <= counter_tick_out & ~mode_capture & (counter_out == channel_value_out);
      if (mode_compare)
      begin
        if (counter_tick_out && counter_out == channel_value_out)
          channel_pin_out <= ~channel_pin_out;
      end
      else if (mode_pulse)
        channel_pin_out <= (counter_out < channel_value_out);
      else
        channel_pin_out <= 1'b0;
    end
  end

endmodule // tvc_channel_value

/* File: tvc_chk.sv */
// Assertion checker for the channel value coherency block
`timescale 1ns/10ps
module tvc_chk
(
  // Clock and reset
  input logic        mclk_in,
  input logic        rst_n_in,
  // Controls
  input logic [1:0]  clock_source_select_in,
  input logic [15:0] counter_modulo_value_in,
  input logic [1:0]  chan_mode_in,
  input logic        channel_status_control_wr_in,
  input logic        background_debug_active_in,
  input logic        capture_in,
  input logic        channel_value_high_wr_in,
  input logic        channel_value_low_wr_in,
  input logic [7:0]  wr_data_in,
  input logic        channel_value_high_rd_in,
  input logic        channel_value_low_rd_in,
  // Responses
  input logic [7:0]  rd_data_out,
  input logic [15:0] channel_value_out,
  input logic [15:0] counter_out,
  input logic        counter_tick_out,
  input logic        pair_pending_out,
  input logic        read_latched_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire        dbg = background_debug_active_in;
  wire        sc  = channel_status_control_wr_in;
  wire        off = clock_source_select_in == 2'h0;
  wire        cap = chan_mode_in == 2'h0;
  wire        hw  = channel_value_high_wr_in;
  wire        lw  = channel_value_low_wr_in;
  wire [15:0] tm1 = (counter_modulo_value_in == 16'h0000) ? 16'hfffe : counter_modulo_value_in - 16'h0001;

  dbg_read_a: assert property ((dbg && channel_value_high_rd_in) |=>
    rd_data_out == $past(channel_value_out[15:8])) else $error("debug read not live");
  dbg_latch_a: assert property ((dbg && !sc) |=> $stable(read_latched_out))
    else $error("read latch moved in debug");
  dbg_write_a: assert property ((dbg && hw && !cap && !counter_tick_out) |=>
    channel_value_out[15:8] == $past(wr_data_in)) else $error("debug write not direct");
  dbg_pend_a: assert property ((dbg && !sc && !counter_tick_out) |=> $stable(pair_pending_out))
    else $error("write latch moved in debug");
  sc_clear_a: assert property ((sc && !hw && !lw && !channel_value_high_rd_in && !channel_value_low_rd_in) |=>
    !pair_pending_out && !read_latched_out) else $error("latches not cleared");
  cap_drop_a: assert property ((cap && !capture_in && !pair_pending_out) |=> $stable(channel_value_out))
    else $error("value changed in capture mode");
  off_pair_a: assert property ((off && !dbg && !cap && !sc && hw && !lw && !pair_pending_out) ##1
    (off && !dbg && !cap && !sc && lw && !hw) |=> channel_value_out == {$past(wr_data_in, 2), $past(wr_data_in)})
    else $error("pair not applied at second byte");
  pwm_top_a: assert property ((!off && !dbg && chan_mode_in[1] && counter_out != tm1) |=>
    $stable(channel_value_out)) else $error("pulse update off the top step");
endmodule // tvc_chk

/* File: tvc_consts.vh */
// Constants for the timer channel value coherency block
`ifndef TVC_CONSTS_VH
`define TVC_CONSTS_VH

// Channel mode codes on chan_mode_in
`define TVC_MODE_CAPTURE   2'h0
`define TVC_MODE_COMPARE   2'h1
`define TVC_MODE_EDGE_PWM  2'h2
`define TVC_MODE_EDGE_PWM2 2'h3

// Clock source select codes
`define TVC_CLK_OFF        2'h0
`define TVC_CLK_BUS        2'h1
`define TVC_CLK_FIXED      2'h2
`define TVC_CLK_EXT        2'h3

// Counter and value widths, limits and reset values
`define TVC_WIDTH          16
`define TVC_FREE_TOP       16'hffff
`define TVC_FREE_PRE_TOP   16'hfffe
`define TVC_COUNT_RST      16'h0000
`define TVC_VALUE_RST      16'h0000
`define TVC_BYTE_RST       8'h00
`define TVC_ONE            16'h0001
`define TVC_HELD_RST       2'h0
`define TVC_LANES          2
`define TVC_BYTE_W         8

// Prescaler
`define TVC_PRE_WIDTH      7
`define TVC_PRE_RST        7'h00
`define TVC_PRE_ONE        7'h01

// Byte lanes of the channel value
`define TVC_HI_MSB         15
`define TVC_HI_LSB         8
`define TVC_LO_MSB         7
`define TVC_LO_LSB         0

`endif

/* File: tvc_counter.v */
// Central 16-bit counter with clock source select, prescaler and modulo
`timescale 1ns/10ps
`include "tvc_consts.vh"

module tvc_counter
(
  // Clock and reset
  input  wire        mclk_in,
  input  wire        rst_n_in,
  // Configuration
  input  wire [1:0]  clock_source_select_in,
  input  wire [2:0]  prescale_sel_in,
  input  wire        center_aligned_select_in,
  input  wire [15:0] counter_modulo_value_in,
  // Clock sources
  input  wire        fixed_tick_in,
  input  wire        ext_clk_in,
  // Counter state
  output reg  [15:0] count_out,
  output reg         count_up_out,
  output wire        tick_out,
  output wire [15:0] top_out
);

  reg                        ext_s1;
  reg                        ext_s2;
  reg                        ext_s3;
  reg                        ext_level;
  reg  [`TVC_PRE_WIDTH-1:0]  pre_cnt;
  reg                        src_edge;
  wire [`TVC_PRE_WIDTH-1:0]  pre_mask;
  wire                       ext_rise;

  // External clock pin: three stages, change taken when stages two and three agree
  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ext_s1    <= 1'b0;
      ext_s2    <= 1'b0;
      ext_s3    <= 1'b0;
      ext_level <= 1'b0;
    end
    else
    begin
      ext_s1 <= ext_clk_in;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      if (ext_s2 == ext_s3)
        ext_level <= ext_s3;
    end
  end

  assign ext_rise = ext_s2 & ext_s3 & ~ext_level;

  always @*
  begin
    case (clock_source_select_in)
      `TVC_CLK_BUS:   src_edge = 1'b1;
      `TVC_CLK_FIXED: src_edge = fixed_tick_in;
      `TVC_CLK_EXT:   src_edge = ext_rise;
      default:        src_edge = 1'b0;
    endcase
  end

  // Divide by two to the power prescale_sel_in
  assign pre_mask = (`TVC_PRE_ONE << prescale_sel_in) - `TVC_PRE_ONE;
  assign tick_out = src_edge & ((pre_cnt & pre_mask) == pre_mask);
  assign top_out  = (counter_modulo_value_in == `TVC_COUNT_RST) ? `TVC_FREE_TOP : counter_modulo_value_in;

  always @(posedge mclk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pre_cnt      <= `TVC_PRE_RST;
      count_out    <= `TVC_COUNT_RST;
      count_up_out <= 1'b1;
    end
    else
    begin
      if (src_edge)
        pre_cnt <= tick_out ? `TVC_PRE_RST : pre_cnt + `TVC_PRE_ONE;
      if (tick_out)
      begin
        if (center_aligned_select_in)
        begin
          if (count_up_out)
          begin
            if (count_out >= top_out)
            begin
              count_out    <= top_out - `TVC_ONE;
              count_up_out <= 1'b0;
            end
            else
              count_out <= count_out + `TVC_ONE;
          end
          else if (count_out == `TVC_COUNT_RST)
          begin
            count_out    <= `TVC_ONE;
            count_up_out <= 1'b1;
          end
          else
            count_out <= count_out - `TVC_ONE;
        end
        else
        begin
          count_up_out <= 1'b1;
          count_out    <= (count_out >= top_out) ? `TVC_COUNT_RST : count_out + `TVC_ONE;
        end
      end
    end
  end

endmodule // tvc_counter
